// file: design/srbs_consts.vh
// Constants for the serial receiver buffer and status block
`ifndef SRBS_CONSTS_VH
`define SRBS_CONSTS_VH
// Behaviour
// RULE_01 - Receive-complete flag high while buffer holds an unread character, else low
// RULE_02 - Writing receiver enable to 0 flushes buffer; receive-complete reads zero
// RULE_03 - Interrupt requested while flag set, its enable and global enable set
// RULE_04 - Each data register read advances buffer, exposing next character and flags
// RULE_05 - Frame, overrun and parity error flags stored and shown with their character
// RULE_06 - Status register writes leave the three error flags unchanged
// RULE_07 - Software writes zero into the three error flag positions
// RULE_08 - No interrupt request comes from any error flag
// RULE_09 - Frame error set when first stop bit sampled zero, clear when one
// RULE_10 - Only first stop bit checked, whatever the stop bit count
// RULE_11 - Overrun when buffer full, shifter holds character and new start detected
// RULE_12 - Overrun indication cleared when a frame moves into the buffer
// RULE_13 - Parity checked only when parity enable is 1; odd select picks odd/even
// RULE_14 - Received data parity compared with parity bit, result buffered with character
// RULE_15 - Parity error reads zero for characters received with checking disabled
// RULE_16 - Parity error stays valid until the data register is read
// RULE_17 - Clearing receiver enable is immediate, dropping reception and buffered data
// RULE_18 - Disabled receiver releases the receive pin to its port function
// RULE_19 - Software reads status before the data register for each character
// RULE_20 - Software flushes by reading data until receive-complete goes low
// RULE_21 - Interrupt enable allows interrupt; handler must read data or it repeats
// RULE_22 - With size 7 the ninth bit shows in control register, read first
// RULE_23 - Frame moves to buffer at first stop bit; second stop bit ignored
// RULE_24 - Each bit decided by majority of three centre samples
// RULE_25 - Entry holds nine data bits and three error bits; unused bits zero
// RULE_26 - On overrun buffered characters kept and the new character dropped

// ============================================================
// Register byte addresses
`define SRBS_ADDR_DATA    8'h00
`define SRBS_ADDR_STATUS  8'h04
`define SRBS_ADDR_CONTROL 8'h08
`define SRBS_ADDR_FORMAT  8'h0c
`define SRBS_ADDR_BAUD    8'h10

// ============================================================
// Status register fields
`define SRBS_ST_PE   2
`define SRBS_ST_OVR  3
`define SRBS_ST_FE   4
`define SRBS_ST_RXC  7

// Control register fields
`define SRBS_CT_NINTH 1
`define SRBS_CT_RXEN  4
`define SRBS_CT_RXCIE 7

// Format register fields
`define SRBS_FM_SIZE_LO 1
`define SRBS_FM_SIZE_HI 3
`define SRBS_FM_STOP    4
`define SRBS_FM_PODD    5
`define SRBS_FM_PEN     6

// ============================================================
// Reset values and timing
`define SRBS_RST_CONTROL 8'h00
`define SRBS_RST_FORMAT  8'h06
`define SRBS_RST_BAUD    16'h0000
`define SRBS_SIZE_NINE   3'h7
`define SRBS_SAMPLES     5'h10
`define SRBS_VOTE_A      4'h7
`define SRBS_VOTE_B      4'h8
`define SRBS_VOTE_C      4'h9
`define SRBS_START_MID   4'h9
`endif

// file: design/srbs_receiver.v
// Serial receiver with two-entry buffer, error flags and Wishbone registers
`timescale 1ns/1ps
`include "srbs_consts.vh"

module srbs_receiver #(
  parameter DEPTH = 2
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire [7:0]  i_wb_adr,
  input  wire [31:0] i_wb_dat,
  input  wire [3:0]  i_wb_sel,
  input  wire        i_wb_we,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_global_irq_enable,
  input  wire        i_serial_receive_pin,
  output wire        o_pin_override,
  output wire        o_irq
);

  // ============================================================
  // Register state
  reg  [7:0]  control;
  reg  [7:0]  format;
  reg  [15:0] baud_div;
  wire        receiver_enable_bit = control[`SRBS_CT_RXEN];
  wire        receive_complete_irq_enable = control[`SRBS_CT_RXCIE];
  wire [2:0]  character_size_field = format[`SRBS_FM_SIZE_HI:`SRBS_FM_SIZE_LO];
  wire        parity_enable_bit = format[`SRBS_FM_PEN];
  wire        parity_odd_select_bit = format[`SRBS_FM_PODD];

  wire bus_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire bus_wr     = bus_req & i_wb_we & i_wb_sel[0];
  wire data_rd    = bus_req & ~i_wb_we & (i_wb_adr == `SRBS_ADDR_DATA);
  wire ctrl_wr    = bus_wr & (i_wb_adr == `SRBS_ADDR_CONTROL);

  // Disable acts in the very cycle of the write, not one later
  wire next_enable = ctrl_wr ? i_wb_dat[`SRBS_CT_RXEN] : receiver_enable_bit;
  wire flush       = ctrl_wr & ~i_wb_dat[`SRBS_CT_RXEN]; // RULE_17

  assign o_pin_override = receiver_enable_bit; // RULE_18

  // ============================================================
  // Oversample tick: divider gives 16 ticks per bit
  reg  [15:0] div_cnt;
  wire        tick = (div_cnt == 16'h0000);
  always @(posedge i_clk) begin
    if (i_srst || !receiver_enable_bit || tick)
      div_cnt <= baud_div;
    else
      div_cnt <= div_cnt - 16'h0001;
  end

  // ============================================================
  // Receive state machine
  localparam ST_IDLE  = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_BITS  = 4'b0100;
  localparam ST_STOP  = 4'b1000;

  reg  [3:0] state;
  reg  [3:0] phase;
  reg  [3:0] bit_idx;
  reg  [9:0] shift;
  reg  [2:0] votes;
  reg        line_prev;
  reg        held_valid;
  reg  [8:0] held_data;
  reg        held_fe;
  reg        held_pe;
  reg        ovr_pending;

  // Data bits plus optional parity bit
  wire [3:0] data_bits = (character_size_field == `SRBS_SIZE_NINE) ? 4'h9 :
                         ({2'b00, character_size_field[1:0]} + 4'h5);
  wire [3:0] frame_bits = data_bits + {3'b000, parity_enable_bit};
  wire       voted = (votes[0] & votes[1]) | (votes[0] & votes[2]) |
                     (votes[1] & votes[2]); // RULE_24

  // ============================================================
  // Buffer storage: data, frame, overrun and parity per entry
  reg  [11:0] fifo [0:DEPTH-1];
  reg  [1:0]  count;
  reg         rd_ptr;
  wire        buf_full = (count == DEPTH[1:0]);
  wire [11:0] head = fifo[rd_ptr];
  wire        push = held_valid & ~buf_full & ~flush;
  wire        pop  = data_rd & (count != 2'h0);
  wire        wr_ptr = rd_ptr + count[0];

  // Parity over received data bits, masked to the character width
  reg  [8:0] rx_data;
  reg        par_calc;
  integer    k;
  always @* begin
    rx_data = 9'h000;
    for (k = 0; k < 9; k = k + 1)
      if (k < data_bits)
        rx_data[k] = shift[10 - frame_bits + k];
    par_calc = ^rx_data ^ parity_odd_select_bit;
  end

  always @(posedge i_clk) begin
    if (i_srst || !next_enable) begin
      state       <= ST_IDLE; // RULE_17
      phase       <= 4'h0;
      bit_idx     <= 4'h0;
      shift       <= 10'h000;
      votes       <= 3'b000;
      line_prev   <= 1'b1;
      held_valid  <= 1'b0;
      held_data   <= 9'h000;
      held_fe     <= 1'b0;
      held_pe     <= 1'b0;
      ovr_pending <= 1'b0;
    end else begin
      if (push) begin
        held_valid  <= 1'b0;
        ovr_pending <= 1'b0; // RULE_12
      end
      if (tick) begin
        line_prev <= i_serial_receive_pin;
        phase     <= phase + 4'h1;
        if (phase == `SRBS_VOTE_A)
          votes[0] <= i_serial_receive_pin;
        if (phase == `SRBS_VOTE_B)
          votes[1] <= i_serial_receive_pin;
        if (phase == `SRBS_VOTE_C)
          votes[2] <= i_serial_receive_pin;
        case (state)
          ST_IDLE: begin
            phase <= 4'h1;
            if (line_prev && !i_serial_receive_pin) begin
              state <= ST_START;
              // New start while buffer and shifter are both full
              if (held_valid && buf_full)
                ovr_pending <= 1'b1; // RULE_11
            end
          end
          ST_START: begin
            if (phase == `SRBS_START_MID + 4'h1) begin
              if (voted) begin
                state <= ST_IDLE;
              end else begin
                state   <= ST_BITS;
                bit_idx <= 4'h0;
              end
            end
          end
          ST_BITS: begin
            if (phase == `SRBS_START_MID + 4'h1) begin
              shift   <= {voted, shift[9:1]};
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx + 4'h1 == frame_bits)
                state <= ST_STOP;
            end
          end
          ST_STOP: begin
            // Only the first stop bit is used; a second passes as idle
            if (phase == `SRBS_START_MID + 4'h1) begin
              state <= ST_IDLE; // RULE_10 RULE_23
              // Held frame still blocked: new one is dropped
              if (!(held_valid && !push)) begin // RULE_26
                held_valid <= 1'b1;
                held_data  <= rx_data;
                held_fe    <= ~voted; // RULE_09
                held_pe    <= parity_enable_bit &
                              (par_calc != shift[9]); // RULE_13 RULE_14 RULE_15
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // Two-entry buffer control
  always @(posedge i_clk) begin
    if (i_srst || !next_enable) begin
      count  <= 2'h0; // RULE_02
      rd_ptr <= 1'b0;
    end else begin
      if (push)
        fifo[wr_ptr] <= {held_fe, ovr_pending, held_pe, held_data}; // RULE_05 RULE_25
      if (pop)
        rd_ptr <= ~rd_ptr; // RULE_04 RULE_16
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  wire receive_complete_flag = (count != 2'h0); // RULE_01
  wire frame_error_flag  = receive_complete_flag & head[11];
  wire overrun_flag      = receive_complete_flag & head[10];
  wire parity_error_flag = receive_complete_flag & head[9];
  wire received_ninth_bit = receive_complete_flag & head[8]; // RULE_22

  // Error flags never reach the interrupt
  assign o_irq = receive_complete_flag & receive_complete_irq_enable &
                 i_global_irq_enable; // RULE_03 RULE_08 RULE_21

  // ============================================================
  // Wishbone slave: one wait-free ack per request
  always @(posedge i_clk) begin
    if (i_srst) begin
      control  <= `SRBS_RST_CONTROL;
      format   <= `SRBS_RST_FORMAT;
      baud_div <= `SRBS_RST_BAUD;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_wr) begin
        // Status writes store nothing: error flags are buffer state
        case (i_wb_adr)
          `SRBS_ADDR_STATUS:  ; // RULE_06
          `SRBS_ADDR_CONTROL: control <= {i_wb_dat[7:2], 1'b0, i_wb_dat[0]};
          `SRBS_ADDR_FORMAT:  format <= i_wb_dat[7:0];
          `SRBS_ADDR_BAUD:    baud_div <= i_wb_dat[15:0];
          default:            ;
        endcase
      end
      if (bus_req && !i_wb_we) begin
        case (i_wb_adr)
          `SRBS_ADDR_DATA:    o_wb_dat <= {24'h000000, head[7:0] & {8{receive_complete_flag}}};
          `SRBS_ADDR_STATUS:  o_wb_dat <= {24'h000000, receive_complete_flag, 2'b00,
                                           frame_error_flag, overrun_flag,
                                           parity_error_flag, 2'b00};
          `SRBS_ADDR_CONTROL: o_wb_dat <= {24'h000000, control[7:2],
                                           received_ninth_bit, control[0]};
          `SRBS_ADDR_FORMAT:  o_wb_dat <= {24'h000000, format};
          `SRBS_ADDR_BAUD:    o_wb_dat <= {16'h0000, baud_div};
          default:            o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // srbs_receiver

// file: verification/serial_receiver_buffer_status_test.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module serial_receiver_buffer_status_test;
  reg         i_clk = 1'h0;
  reg         i_srst = 1'h1;
  reg  [7:0]  adr = 8'h0;
  reg  [31:0] wdat = 32'h0;
  reg         we = 1'h0;
  reg         cyc = 1'h0;
  reg         gie = 1'h1;
  reg  [31:0] q;
  reg  [7:0]  d;
  wire [31:0] rdat;
  wire        ack, line, pin_ovr, irq;
  integer     fails = 0, num_checks = 0, cycles = 0, i;
`define CHK(n, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("MISMATCH %s exp %h got %h", n, e, g); end end
  srbs_receiver i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(4'hf), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(cyc), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_global_irq_enable(gie), .i_serial_receive_pin(line),
    .o_pin_override(pin_ovr), .o_irq(irq));
  srbs_line_model i_line (.i_clk(i_clk), .o_line(line));
  // ==========
  // Clock, timeout and tasks
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      fails = fails + 1;
      results;
    end
  end
  task results;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task xfer(input [7:0] a, input w, input [31:0] v);
    begin
      @(posedge i_clk);
      cyc <= 1'h1;
      adr <= a;
      we <= w;
      wdat <= v;
      @(posedge i_clk);
      while (ack !== 1'h1) @(posedge i_clk);
      q = rdat;
      cyc <= 1'h0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'h0, 32'h0);
      `CHK($sformatf("reg %h", a), e, q)
    end
  endtask
  // ==========
  // Sequence
  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'h0;
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h6);
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    xfer(8'h08, 1'h1, 32'h90);
    `CHK("override", 1'h1, pin_ovr)
    i_line.send(9'ha5, 8, 1'h0, 1'h0, 1'h1);
    gie <= 1'h0;
    @(posedge i_clk);
    `CHK("irq", 1'h0, irq)
    gie <= 1'h1;
    @(posedge i_clk);
    `CHK("irq", 1'h1, irq)
    rd(8'h04, 32'h80);
    rd(8'h00, 32'ha5);
    rd(8'h04, 32'h0);
    `CHK("irq", 1'h0, irq)
    i_line.spike(3);
    rd(8'h04, 32'h0);
    // Slower bit clock with the interrupt masked
    xfer(8'h08, 1'h1, 32'h10);
    xfer(8'h10, 1'h1, 32'h1);
    rd(8'h10, 32'h1);
    i_line.clks_per_tick <= 2;
    i_line.send(9'h96, 8, 1'h0, 1'h0, 1'h1);
    `CHK("irq", 1'h0, irq)
    rd(8'h04, 32'h80);
    rd(8'h00, 32'h96);
    xfer(8'h10, 1'h1, 32'h0);
    i_line.clks_per_tick <= 1;
    xfer(8'h08, 1'h1, 32'h90);
    // Bad first stop with two stop bits selected
    xfer(8'h0c, 1'h1, 32'h16);
    i_line.send(9'h3c, 8, 1'h0, 1'h0, 1'h0);
    rd(8'h04, 32'h90);
    xfer(8'h04, 1'h1, 32'h0);
    rd(8'h04, 32'h90);
    rd(8'h00, 32'h3c);
    for (i = 0; i < 4; i = i + 1) begin
      d = 8'h5a + i[7:0];
      xfer(8'h0c, 1'h1, {25'h0, 1'h1, i[1], 5'h06});
      i_line.send({1'h0, d}, 8, 1'h1, (^d) ^ i[1] ^ i[0], 1'h1);
      rd(8'h04, {24'h0, 1'h1, 4'h0, i[0], 2'h0});
      rd(8'h00, {24'h0, d});
    end
    for (i = 0; i < 4; i = i + 1) begin
      xfer(8'h0c, 1'h1, {28'h0, i[1:0], 1'h0});
      i_line.send(9'h1ff, 5 + i, 1'h0, 1'h1, 1'h1);
      rd(8'h04, 32'h80);
      rd(8'h00, {24'h0, 8'hff >> (3 - i)});
    end
    xfer(8'h0c, 1'h1, 32'he);
    i_line.send(9'h1c3, 9, 1'h0, 1'h0, 1'h1);
    rd(8'h08, 32'h92);
    rd(8'h00, 32'hc3);
    // Four frames unread: third waits, fourth is lost
    xfer(8'h0c, 1'h1, 32'h6);
    for (i = 0; i < 4; i = i + 1) i_line.send(9'h10 + i[8:0], 8, 1'h0, 1'h0, 1'h1);
    rd(8'h04, 32'h80);
    rd(8'h00, 32'h10);
    rd(8'h00, 32'h11);
    rd(8'h04, 32'h88);
    rd(8'h00, 32'h12);
    rd(8'h04, 32'h0);
    i_line.send(9'h55, 8, 1'h0, 1'h0, 1'h1);
    rd(8'h04, 32'h80);
    xfer(8'h08, 1'h1, 32'h80);
    `CHK("irq", 1'h0, irq)
    rd(8'h04, 32'h0);
    `CHK("override", 1'h0, pin_ovr)
    results;
  end
endmodule // serial_receiver_buffer_status_test

// file: verification/srbs_asserts.sv
// Port checker for the serial receiver
`timescale 1ns/1ps
module srbs_asserts (
  input wire        i_clk,
  input wire        i_srst,
  input wire [7:0]  i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0]  i_wb_sel,
  input wire        i_wb_we,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  input wire        i_global_irq_enable,
  input wire        o_pin_override,
  input wire        o_irq
);
  // ==========
  // Shadow of control enables
  wire take   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire ctl_wr = take & i_wb_we & i_wb_sel[0] & (i_wb_adr == 8'h08);
  reg  ie_sh;
  reg  en_sh;
  always @(posedge i_clk) begin
    if (i_srst) begin
      ie_sh <= 1'h0;
      en_sh <= 1'h0;
    end else if (ctl_wr) begin
      ie_sh <= i_wb_dat[7];
      en_sh <= i_wb_dat[4];
    end
  end
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_answer: assert property (take |=> o_wb_ack) else $error("request unanswered");
  a_ack_unasked: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without request");
  a_irq_global: assert property (!i_global_irq_enable |-> !o_irq) else $error("irq unmasked");
  a_irq_masked: assert property (!ie_sh |-> !o_irq) else $error("irq while disabled");
  a_pin_release: assert property (o_pin_override == en_sh) else $error("pin override");
  a_flush_drops: assert property (ctl_wr && !i_wb_dat[4] |=> !o_irq)
    else $error("flush kept data");
  a_data_width: assert property (o_wb_ack && i_wb_adr == 8'h00 |-> o_wb_dat[31:8] == 24'h0)
    else $error("data high bits");
  a_irq_holds: assert property (o_irq && !take |=> o_irq || !i_global_irq_enable)
    else $error("irq dropped unread");
endmodule // srbs_asserts

bind srbs_receiver srbs_asserts i_chk (.i_clk(i_clk), .i_srst(i_srst), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .i_wb_we(i_wb_we), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_global_irq_enable(i_global_irq_enable), .o_pin_override(o_pin_override), .o_irq(o_irq));

// file: verification/srbs_line_model.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module srbs_line_model (
  input  wire i_clk,
  output reg  o_line
);
  // ==========
  // Frame sender; one bit is 16 ticks of clks_per_tick clocks
  integer clks_per_tick = 1;
  initial o_line = 1'h1;
  task hold_bit(input v);
    begin
      o_line <= v;
      repeat (16 * clks_per_tick) @(posedge i_clk);
    end
  endtask
  // Trailing idle bit also acts as a second stop bit
  task send(input [8:0] d, input integer n, input pen, input pbit, input stop);
    integer k;
    begin
      @(posedge i_clk);
      hold_bit(1'h0);
      for (k = 0; k < n; k = k + 1) hold_bit(d[k]);
      if (pen) hold_bit(pbit);
      hold_bit(stop);
      hold_bit(1'h1);
    end
  endtask
  // Short low pulse the receiver must reject as noise, then idle
  task spike(input integer n);
    begin
      @(posedge i_clk);
      o_line <= 1'h0;
      repeat (n) @(posedge i_clk);
      o_line <= 1'h1;
      repeat (32) @(posedge i_clk);
    end
  endtask
endmodule // srbs_line_model
